// ==== dcu_chk.sv ====
// Concurrent checks on the drive command unit ports
`timescale 1ns/1ps
`default_nettype none
module dcu_chk #(
	parameter int NUM_OUT = 2
) (
	// Clock and reset
	input wire logic			clk_sys_i,
	input wire logic			srst_i,
	// Settings and requests
	input wire logic [NUM_OUT*4-1:0]	out_sel_i,
	input wire logic			mb_wr_i,
	input wire logic [15:0]		mb_addr_i,
	input wire logic [15:0]		mb_wdata_i,
	input wire logic			ser_rd_i,
	input wire logic [7:0]		ser_code_i,
	// Results
	input wire logic [15:0]		ser_rdata_o,
	input wire logic			ser_rvalid_o,
	input wire logic			mb_rvalid_o,
	input wire logic			diff_clr_o,
	input wire logic			loop_open_o,
	input wire logic signed [24:0]	rate_o,
	input wire logic			slowdown_o,
	input wire logic			move_active_o,
	input wire logic [NUM_OUT-1:0]	stat_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);

	// Clear acts on the edge only, never as a level
	a_clr_edge_pulse: assert property (diff_clr_o |=> !diff_clr_o)
		else $error("counter clear held longer than one cycle");
	a_closed_rate: assert property (
		(!loop_open_o) [*2] |-> rate_o == 25'sh000_0000)
		else $error("rate nonzero with loop closed");
	a_open_idle_min: assert property (
		(loop_open_o && !move_active_o) [*3] |-> rate_o == 25'sh000_0001)
		else $error("open loop idle rate is not the lowest rate");
	a_decouple_write: assert property (
		(mb_wr_i && mb_addr_i == dcu_pkg::MB_DECOUPLE &&
		mb_wdata_i == dcu_pkg::CMD_SET) |-> ##[1:4] loop_open_o)
		else $error("decouple write did not open the loop");
	a_slow_write: assert property (
		(mb_wr_i && mb_addr_i == dcu_pkg::MB_SLOWDOWN &&
		mb_wdata_i == dcu_pkg::CMD_SET) |-> ##[1:4] slowdown_o)
		else $error("slowdown write not seen at output");
	a_align_readback: assert property (
		(mb_wr_i && mb_addr_i == dcu_pkg::MB_ALIGN &&
		mb_wdata_i == dcu_pkg::CMD_SET) ##2
		(ser_rd_i && ser_code_i == dcu_pkg::SER_ALIGN)
		|=> ser_rdata_o == 16'h0001)
		else $error("align set by one port not read on the other");
	a_ser_rd_valid: assert property (
		ser_rd_i |=> ser_rvalid_o && !mb_rvalid_o)
		else $error("serial read answer missing or on wrong port");
	a_ser_rd_quiet: assert property (
		!ser_rd_i |=> !ser_rvalid_o)
		else $error("serial read valid without a request");
	// Status lags by one register, so only settled values are compared
	a_dir_status: assert property (
		(out_sel_i[3:0] == dcu_pkg::OSEL_DIR && $stable(rate_o)) [*2]
		|-> stat_o[0] == (rate_o > 25'sh000_0000))
		else $error("direction status disagrees with rate sign");
	a_move_status: assert property (
		(out_sel_i[7:4] == dcu_pkg::OSEL_MOVE && $stable(move_active_o)) [*2]
		|-> stat_o[1] == move_active_o)
		else $error("movement status disagrees with movement");

	c_move: cover property ($rose(move_active_o));
	c_clear: cover property (diff_clr_o);
	c_slow: cover property ($fell(slowdown_o));
endmodule

bind dcu_top dcu_chk #(.NUM_OUT(NUM_OUT)) u_chk (
	.clk_sys_i, .srst_i, .out_sel_i, .mb_wr_i, .mb_addr_i, .mb_wdata_i,
	.ser_rd_i, .ser_code_i, .ser_rdata_o, .ser_rvalid_o, .mb_rvalid_o,
	.diff_clr_o, .loop_open_o, .rate_o, .slowdown_o, .move_active_o,
	.stat_o
);
`default_nettype wire

// ==== dcu_host.sv ====
// Host model issuing serial and Modbus command words
`timescale 1ns/1ps
`default_nettype none
module dcu_host (
	// Clock
	input  wire logic		clk_sys_i,
	// Serial port
	output logic		ser_wr_o,
	output logic		ser_rd_o,
	output logic [7:0]	ser_code_o,
	output logic [15:0]	ser_wdata_o,
	input  wire logic [15:0]	ser_rdata_i,
	input  wire logic		ser_rvalid_i,
	// Modbus port
	output logic		mb_wr_o,
	output logic		mb_rd_o,
	output logic [15:0]	mb_addr_o,
	output logic [15:0]	mb_wdata_o,
	input  wire logic [15:0]	mb_rdata_i,
	input  wire logic		mb_rvalid_i
);
	initial begin
		{ser_wr_o, ser_rd_o, mb_wr_o, mb_rd_o} = 4'h0;
		{ser_code_o, ser_wdata_o, mb_addr_o, mb_wdata_o} = 56'h0;
	end

	// Each call takes its own edge first, so strobes never collide
	task automatic wr(input logic mb, input logic [15:0] a, d);
		@(posedge clk_sys_i);
		#2;
		ser_code_o = a[7:0];
		mb_addr_o = a;
		ser_wdata_o = d;
		mb_wdata_o = d;
		ser_wr_o = !mb;
		mb_wr_o = mb;
		@(posedge clk_sys_i);
		#2;
		ser_wr_o = 1'h0;
		mb_wr_o = 1'h0;
		// Released data toggles so a stale word is never mistaken
		ser_wdata_o = ~d;
		mb_wdata_o = ~d;
	endtask

	// Returns the valid flag above the 16 data bits
	task automatic rd(input logic mb, input logic [15:0] a,
			output logic [16:0] q);
		@(posedge clk_sys_i);
		#2;
		ser_code_o = a[7:0];
		mb_addr_o = a;
		ser_rd_o = !mb;
		mb_rd_o = mb;
		@(posedge clk_sys_i);
		#2;
		ser_rd_o = 1'h0;
		mb_rd_o = 1'h0;
		q = mb ? {mb_rvalid_i, mb_rdata_i} : {ser_rvalid_i, ser_rdata_i};
	endtask

	// Loop is opened ahead of any move; direction is up to the caller
	task automatic jog(input logic on);
		if (on)
			wr(1'h1, dcu_pkg::MB_DECOUPLE, dcu_pkg::CMD_SET);
		wr(1'h0, 16'(dcu_pkg::SER_MOVE), 16'(on));
	endtask
endmodule
`default_nettype wire

// ==== dcu_pkg.sv ====
// Constants and types shared by the drive command unit
package dcu_pkg;

	// Input command codes assigned to a control input
	localparam logic [3:0] FN_CLEAR    = 4'h1;
	localparam logic [3:0] FN_DECOUPLE = 4'h2;
	localparam logic [3:0] FN_MOVE     = 4'h4;
	localparam logic [3:0] FN_SLOWDOWN = 4'h9;
	localparam logic [3:0] FN_ALIGN    = 4'hC;

	// Serial command codes (decimal numbers in hex form)
	localparam logic [7:0] SER_TALLY    = 8'h04;
	localparam logic [7:0] SER_DECOUPLE = 8'h37;
	localparam logic [7:0] SER_SLOWDOWN = 8'h39;
	localparam logic [7:0] SER_MOVE     = 8'h3B;
	localparam logic [7:0] SER_CLEAR    = 8'h3C;
	localparam logic [7:0] SER_ALIGN    = 8'h45;

	// Modbus register addresses
	localparam logic [15:0] MB_CLEAR    = 16'hFF04;
	localparam logic [15:0] MB_DECOUPLE = 16'hFF06;
	localparam logic [15:0] MB_MOVE     = 16'hFF08;
	localparam logic [15:0] MB_SLOWDOWN = 16'hFF12;
	localparam logic [15:0] MB_ALIGN    = 16'hFF16;

	// Command word values and reset value of each command register
	localparam logic [15:0] CMD_RELEASE = 16'h0000;
	localparam logic [15:0] CMD_SET     = 16'h0001;
	localparam logic        CMD_RST     = 1'b0;

	// Output signal selects and alternate behaviour values
	localparam logic [3:0] OSEL_DIR  = 4'h3;
	localparam logic [3:0] OSEL_MOVE = 4'h6;
	localparam logic [1:0] ALT_TALLY = 2'h1;
	localparam logic [1:0] ALT_NONE  = 2'h0;

	// Lowest output rate in 0.1 Hz units (about 0.1 Hz)
	localparam logic [23:0] RATE_MIN = 24'h00_0001;

	// Ramp time unit and clock period, both in ns
	localparam longint RAMP_UNIT_NS  = 10000000;
	localparam longint CLK_PERIOD_NS = 25;
	localparam logic [39:0] RAMP_UNIT_CYC =
		40'(RAMP_UNIT_NS / CLK_PERIOD_NS);

	// Manual ramp states
	typedef enum logic [1:0] {
		DCU_IDLE,
		DCU_RISE,
		DCU_HOLD,
		DCU_FALL
	} dcu_ramp_t;

endpackage

// ==== dcu_top.sv ====
// Drive command unit: command sources, manual ramp, index align, status
// Function
// [RULE1] Polarity 0 makes an input active low; polarity 1 active high.
// [RULE2] Input code 1 clears the differential counter on the command edge.
// [RULE3] Alternate select 1: the clear edge also zeroes the offset tally.
// [RULE4] Serial 60 or Modbus FF04 sets counter clear with 1, releases with 0.
// [RULE5] Index align (code 12) lets each input index pulse zero the counter.
// [RULE6] Serial 69 or Modbus FF16 sets index align with 1, releases with 0.
// [RULE7] Static index level: align active suppresses, inactive passes pulses.
// [RULE8] Loop decouple (code 2) opens the loop, output at lowest rate.
// [RULE9] Serial 55 or Modbus FF06 sets loop decouple with 1, releases with 0.
// [RULE10] Commander sets loop decouple before the manual move command.
// [RULE11] Manual move (code 4) ramps up, holds, ramps down on release.
// [RULE12] Zero ramp time makes the output jump on set and on release.
// [RULE13] Direction makes the end point negative; apply it before the move.
// [RULE14] Release during the rising ramp ramps down from the present value.
// [RULE15] Re-set while falling, alternate zero: jump to zero, then rise.
// [RULE16] Re-set while falling, alternate nonzero: rise from present value.
// [RULE17] A target rate change during motion takes effect as a step. Code steps only in hold or to a lower target while rising.
// [RULE18] Serial 59 or Modbus FF08 sets manual move with 1, releases with 0.
// [RULE19] Output select 3 shows the direction of the output frequency.
// [RULE20] Output select 6 is high for the whole manual movement.
// [RULE21] Slowdown switch from input code 9, serial 57 or Modbus FF12.
// [RULE22] The ramp steps linearly each cycle across the configured time. Code steps at most one unit per cycle; targets above ramp_cyc take longer.
`timescale 1ns/1ps
`default_nettype none

module dcu_top #(
	parameter int NUM_IN  = 4,
	parameter int NUM_OUT = 2,
	parameter int IDX_W   = 16
) (
	// Clock and reset
	input  wire logic                    clk_sys_i,
	input  wire logic                    srst_i,
	// Control inputs and their settings
	input  wire logic [NUM_IN-1:0]       ctl_in_i,
	input  wire logic [NUM_IN-1:0]       in_pol_i,
	input  wire logic [NUM_IN*4-1:0]     in_func_i,
	// Behaviour settings
	input  wire logic [1:0]              alt_mode_i,
	input  wire logic [23:0]             manual_rate_i,
	input  wire logic [15:0]             ramp_time_i,
	input  wire logic                    dir_cmd_i,
	input  wire logic [NUM_OUT*4-1:0]    out_sel_i,
	// Serial command words
	input  wire logic                    ser_wr_i,
	input  wire logic                    ser_rd_i,
	input  wire logic [7:0]              ser_code_i,
	input  wire logic [15:0]             ser_wdata_i,
	output logic [15:0]                  ser_rdata_o,
	output logic                         ser_rvalid_o,
	// Modbus register access
	input  wire logic                    mb_wr_i,
	input  wire logic                    mb_rd_i,
	input  wire logic [15:0]             mb_addr_i,
	input  wire logic [15:0]             mb_wdata_i,
	output logic [15:0]                  mb_rdata_o,
	output logic                         mb_rvalid_o,
	// Offset pulses and index signals
	input  wire logic                    ofs_inc_i,
	input  wire logic                    ofs_dec_i,
	input  wire logic                    idx_in_i,
	input  wire logic                    out_step_i,
	input  wire logic [IDX_W-1:0]        idx_period_i,
	// Results
	output logic                         diff_clr_o,
	output logic                         loop_open_o,
	output logic signed [24:0]           rate_o,
	output logic                         idx_out_o,
	output logic                         slowdown_o,
	output logic                         move_active_o,
	output logic [NUM_OUT-1:0]           stat_o
);

	// Any input whose function matches code and which is active
	function automatic logic in_cmd(input logic [3:0] code,
			input logic [NUM_IN-1:0] lvl,
			input logic [NUM_IN-1:0] pol,
			input logic [NUM_IN*4-1:0] fn);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < NUM_IN; i++) begin
			if (fn[i*4 +: 4] == code && lvl[i] == pol[i]) begin
				hit = 1'b1; // [RULE1]
			end
		end
		return hit;
	endfunction

	// A command word: 1 sets, 0 releases, other values leave it alone
	function automatic logic cmd_word(input logic [15:0] data,
			input logic cur);
		logic res;
		res = cur;
		if (data == dcu_pkg::CMD_SET) begin
			res = 1'b1;
		end else if (data == dcu_pkg::CMD_RELEASE) begin
			res = 1'b0;
		end
		return res;
	endfunction

	// Command register bits, written by serial or Modbus
	logic clr_reg_ff;
	logic dec_reg_ff;
	logic mov_reg_ff;
	logic slw_reg_ff;
	logic aln_reg_ff;

	logic ser_w_clr;
	logic ser_w_dec;
	logic ser_w_mov;
	logic ser_w_slw;
	logic ser_w_aln;
	logic mb_w_clr;
	logic mb_w_dec;
	logic mb_w_mov;
	logic mb_w_slw;
	logic mb_w_aln;

	assign ser_w_clr = ser_wr_i && ser_code_i == dcu_pkg::SER_CLEAR;
	assign ser_w_dec = ser_wr_i && ser_code_i == dcu_pkg::SER_DECOUPLE;
	assign ser_w_mov = ser_wr_i && ser_code_i == dcu_pkg::SER_MOVE;
	assign ser_w_slw = ser_wr_i && ser_code_i == dcu_pkg::SER_SLOWDOWN;
	assign ser_w_aln = ser_wr_i && ser_code_i == dcu_pkg::SER_ALIGN;
	assign mb_w_clr  = mb_wr_i && mb_addr_i == dcu_pkg::MB_CLEAR;
	assign mb_w_dec  = mb_wr_i && mb_addr_i == dcu_pkg::MB_DECOUPLE;
	assign mb_w_mov  = mb_wr_i && mb_addr_i == dcu_pkg::MB_MOVE;
	assign mb_w_slw  = mb_wr_i && mb_addr_i == dcu_pkg::MB_SLOWDOWN;
	assign mb_w_aln  = mb_wr_i && mb_addr_i == dcu_pkg::MB_ALIGN;

	// Modbus write wins when both ports hit the same command at once
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			clr_reg_ff <= dcu_pkg::CMD_RST;
			dec_reg_ff <= dcu_pkg::CMD_RST;
			mov_reg_ff <= dcu_pkg::CMD_RST;
			slw_reg_ff <= dcu_pkg::CMD_RST;
			aln_reg_ff <= dcu_pkg::CMD_RST;
		end else begin
			if (mb_w_clr) begin
				clr_reg_ff <= cmd_word(mb_wdata_i, clr_reg_ff); // [RULE4]
			end else if (ser_w_clr) begin
				clr_reg_ff <= cmd_word(ser_wdata_i, clr_reg_ff); // [RULE4]
			end
			if (mb_w_dec) begin
				dec_reg_ff <= cmd_word(mb_wdata_i, dec_reg_ff); // [RULE9]
			end else if (ser_w_dec) begin
				dec_reg_ff <= cmd_word(ser_wdata_i, dec_reg_ff); // [RULE9]
			end
			if (mb_w_mov) begin
				mov_reg_ff <= cmd_word(mb_wdata_i, mov_reg_ff); // [RULE18]
			end else if (ser_w_mov) begin
				mov_reg_ff <= cmd_word(ser_wdata_i, mov_reg_ff); // [RULE18]
			end
			if (mb_w_slw) begin
				slw_reg_ff <= cmd_word(mb_wdata_i, slw_reg_ff); // [RULE21]
			end else if (ser_w_slw) begin
				slw_reg_ff <= cmd_word(ser_wdata_i, slw_reg_ff); // [RULE21]
			end
			if (mb_w_aln) begin
				aln_reg_ff <= cmd_word(mb_wdata_i, aln_reg_ff); // [RULE6]
			end else if (ser_w_aln) begin
				aln_reg_ff <= cmd_word(ser_wdata_i, aln_reg_ff); // [RULE6]
			end
		end
	end

	// Effective command levels: input or register, registered once
	logic clr_ff;
	logic dec_ff;
	logic mov_ff;
	logic aln_ff;
	logic clr_q_ff;
	logic mov_q_ff;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			clr_ff     <= 1'b0;
			dec_ff     <= 1'b0;
			mov_ff     <= 1'b0;
			aln_ff     <= 1'b0;
			slowdown_o <= 1'b0;
			clr_q_ff   <= 1'b0;
			mov_q_ff   <= 1'b0;
		end else begin
			clr_ff <= clr_reg_ff
				| in_cmd(dcu_pkg::FN_CLEAR, ctl_in_i, in_pol_i, in_func_i);
			dec_ff <= dec_reg_ff
				| in_cmd(dcu_pkg::FN_DECOUPLE, ctl_in_i, in_pol_i, in_func_i);
			mov_ff <= mov_reg_ff
				| in_cmd(dcu_pkg::FN_MOVE, ctl_in_i, in_pol_i, in_func_i);
			aln_ff <= aln_reg_ff
				| in_cmd(dcu_pkg::FN_ALIGN, ctl_in_i, in_pol_i, in_func_i);
			slowdown_o <= slw_reg_ff
				| in_cmd(dcu_pkg::FN_SLOWDOWN, ctl_in_i, in_pol_i,
					in_func_i); // [RULE21]
			clr_q_ff <= clr_ff;
			mov_q_ff <= mov_ff;
		end
	end

	logic clr_edge;
	assign clr_edge = clr_ff && !clr_q_ff;

	// Counter clear pulse and offset tally
	logic signed [15:0] tally_ff;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			diff_clr_o <= 1'b0;
			tally_ff   <= 16'sh0000;
		end else begin
			diff_clr_o <= clr_edge; // [RULE2]
			if (clr_edge && alt_mode_i == dcu_pkg::ALT_TALLY) begin
				tally_ff <= 16'sh0000; // [RULE3]
			end else if (ofs_inc_i && !ofs_dec_i) begin
				tally_ff <= tally_ff + 16'sh0001;
			end else if (ofs_dec_i && !ofs_inc_i) begin
				tally_ff <= tally_ff - 16'sh0001;
			end
		end
	end

	// Read answers, one cycle after the strobe; unknown codes read zero
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			ser_rdata_o  <= 16'h0000;
			ser_rvalid_o <= 1'b0;
			mb_rdata_o   <= 16'h0000;
			mb_rvalid_o  <= 1'b0;
		end else begin
			ser_rvalid_o <= ser_rd_i;
			mb_rvalid_o  <= mb_rd_i;
			case (ser_code_i)
			dcu_pkg::SER_TALLY:    ser_rdata_o <= tally_ff; // [RULE3]
			dcu_pkg::SER_CLEAR:    ser_rdata_o <= {15'h0000, clr_reg_ff};
			dcu_pkg::SER_DECOUPLE: ser_rdata_o <= {15'h0000, dec_reg_ff};
			dcu_pkg::SER_MOVE:     ser_rdata_o <= {15'h0000, mov_reg_ff};
			dcu_pkg::SER_SLOWDOWN: ser_rdata_o <= {15'h0000, slw_reg_ff};
			dcu_pkg::SER_ALIGN:    ser_rdata_o <= {15'h0000, aln_reg_ff};
			default:               ser_rdata_o <= 16'h0000;
			endcase
			case (mb_addr_i)
			dcu_pkg::MB_CLEAR:    mb_rdata_o <= {15'h0000, clr_reg_ff};
			dcu_pkg::MB_DECOUPLE: mb_rdata_o <= {15'h0000, dec_reg_ff};
			dcu_pkg::MB_MOVE:     mb_rdata_o <= {15'h0000, mov_reg_ff};
			dcu_pkg::MB_SLOWDOWN: mb_rdata_o <= {15'h0000, slw_reg_ff};
			dcu_pkg::MB_ALIGN:    mb_rdata_o <= {15'h0000, aln_reg_ff};
			default:              mb_rdata_o <= 16'h0000;
			endcase
		end
	end

	// Index counter; with align active, a held input index level keeps it zeroed
	logic [IDX_W-1:0] idx_cnt_ff;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			idx_cnt_ff <= '0;
			idx_out_o  <= 1'b0;
		end else if (aln_ff && idx_in_i) begin
			idx_cnt_ff <= '0; // [RULE5]
			idx_out_o  <= 1'b0; // [RULE7]
		end else if (out_step_i) begin
			if (idx_cnt_ff >= idx_period_i - IDX_W'(1)) begin
				idx_cnt_ff <= '0;
				idx_out_o  <= 1'b1; // [RULE7]
			end else begin
				idx_cnt_ff <= idx_cnt_ff + IDX_W'(1);
				idx_out_o  <= 1'b0;
			end
		end else begin
			idx_out_o <= 1'b0;
		end
	end

	// Manual ramp; one rate unit per cycle at most, so a target above
	// the ramp length in cycles makes the ramp slower than set
	dcu_pkg::dcu_ramp_t state_ff;
	dcu_pkg::dcu_ramp_t nxt_state;
	logic [23:0] mag_ff;
	logic [23:0] nxt_mag;
	logic [39:0] acc_ff;
	logic [39:0] nxt_acc;
	logic        dir_ff;
	logic        nxt_dir;
	logic [39:0] ramp_cyc;
	logic        zero_ramp;
	logic        mov_rise;
	logic        mov_fall;

	assign ramp_cyc  = 40'(ramp_time_i) * dcu_pkg::RAMP_UNIT_CYC;
	assign zero_ramp = ramp_time_i == 16'h0000;
	assign mov_rise  = mov_ff && !mov_q_ff;
	assign mov_fall  = !mov_ff && mov_q_ff;

	always_comb begin
		nxt_state = state_ff;
		nxt_mag   = mag_ff;
		nxt_acc   = acc_ff;
		nxt_dir   = dir_ff;
		case (state_ff)
		dcu_pkg::DCU_IDLE: begin
			nxt_mag = 24'h00_0000;
			if (mov_rise) begin
				nxt_dir = dir_cmd_i; // [RULE13]
				nxt_acc = 40'h00_0000_0000;
				if (zero_ramp) begin
					nxt_mag   = manual_rate_i; // [RULE12]
					nxt_state = dcu_pkg::DCU_HOLD;
				end else begin
					nxt_state = dcu_pkg::DCU_RISE; // [RULE11]
				end
			end
		end
		dcu_pkg::DCU_RISE: begin
			if (!mov_ff) begin
				nxt_acc   = 40'h00_0000_0000;
				nxt_state = dcu_pkg::DCU_FALL; // [RULE14]
			end else if (mag_ff >= manual_rate_i) begin
				nxt_mag   = manual_rate_i;
				nxt_state = dcu_pkg::DCU_HOLD;
			end else if (acc_ff + 40'(manual_rate_i) >= ramp_cyc) begin
				nxt_acc = acc_ff + 40'(manual_rate_i) - ramp_cyc;
				nxt_mag = mag_ff + 24'h00_0001; // [RULE22]
			end else begin
				nxt_acc = acc_ff + 40'(manual_rate_i);
			end
		end
		dcu_pkg::DCU_HOLD: begin
			nxt_mag = manual_rate_i; // [RULE17]
			if (mov_fall) begin
				nxt_acc = 40'h00_0000_0000;
				if (zero_ramp) begin
					nxt_mag   = 24'h00_0000; // [RULE12]
					nxt_state = dcu_pkg::DCU_IDLE;
				end else begin
					nxt_state = dcu_pkg::DCU_FALL; // [RULE11]
				end
			end
		end
		dcu_pkg::DCU_FALL: begin
			if (mov_rise) begin
				nxt_dir   = dir_cmd_i;
				nxt_acc   = 40'h00_0000_0000;
				nxt_state = dcu_pkg::DCU_RISE;
				if (alt_mode_i == dcu_pkg::ALT_NONE) begin
					nxt_mag = 24'h00_0000; // [RULE15]
				end // Else rises on from present value [RULE16]
			end else if (mag_ff == 24'h00_0000 || zero_ramp) begin
				nxt_mag   = 24'h00_0000;
				nxt_state = dcu_pkg::DCU_IDLE;
			end else if (acc_ff + 40'(manual_rate_i) >= ramp_cyc) begin
				nxt_acc = acc_ff + 40'(manual_rate_i) - ramp_cyc;
				nxt_mag = mag_ff - 24'h00_0001; // [RULE22]
			end else begin
				nxt_acc = acc_ff + 40'(manual_rate_i);
			end
		end
		default: begin
			nxt_state = dcu_pkg::DCU_IDLE;
			nxt_mag   = 24'h00_0000;
		end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			state_ff <= dcu_pkg::DCU_IDLE;
			mag_ff   <= 24'h00_0000;
			acc_ff   <= 40'h00_0000_0000;
			dir_ff   <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			mag_ff   <= nxt_mag;
			acc_ff   <= nxt_acc;
			dir_ff   <= nxt_dir;
		end
	end

	// Output rate; decouple alone parks the output at the lowest rate
	logic signed [24:0] nxt_rate;
	logic               moving;

	assign moving = nxt_state != dcu_pkg::DCU_IDLE;

	always_comb begin
		if (!dec_ff) begin
			nxt_rate = 25'sh000_0000;
		end else if (moving) begin
			nxt_rate = nxt_dir ? -$signed({1'b0, nxt_mag})
				: $signed({1'b0, nxt_mag}); // [RULE13]
		end else begin
			nxt_rate = $signed({1'b0, dcu_pkg::RATE_MIN}); // [RULE8]
		end
	end

	// Status outputs by select; other selects are driven low here
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			rate_o        <= 25'sh000_0000;
			loop_open_o   <= 1'b0;
			move_active_o <= 1'b0;
			stat_o        <= '0;
		end else begin
			rate_o        <= nxt_rate;
			loop_open_o   <= dec_ff; // [RULE8]
			move_active_o <= moving;
			for (int k = 0; k < NUM_OUT; k++) begin
				case (out_sel_i[k*4 +: 4])
				dcu_pkg::OSEL_DIR:  stat_o[k] <= nxt_rate > 0; // [RULE19]
				dcu_pkg::OSEL_MOVE: stat_o[k] <= moving; // [RULE20]
				default:            stat_o[k] <= 1'b0;
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// ==== drive_command_unit_tb.sv ====
// Self-checking testbench for the drive command unit
`timescale 1ns/1ps
`default_nettype none
module drive_command_unit_tb;
	logic			clk_sys_i = 1'h0;
	logic			srst_i;
	logic [3:0]		ctl_in_i;
	logic [3:0]		in_pol_i;
	logic [15:0]		in_func_i;
	logic [1:0]		alt_mode_i;
	logic [23:0]		manual_rate_i;
	logic [15:0]		ramp_time_i;
	logic			dir_cmd_i;
	logic [7:0]		out_sel_i;
	logic			ofs_inc_i;
	logic			ofs_dec_i;
	logic			idx_in_i;
	logic			out_step_i;
	logic [15:0]		idx_period_i;
	wire logic		ser_wr_i, ser_rd_i, mb_wr_i, mb_rd_i;
	wire logic [7:0]	ser_code_i;
	wire logic [15:0]	ser_wdata_i, mb_addr_i, mb_wdata_i;
	wire logic [15:0]	ser_rdata_o, mb_rdata_o;
	wire logic		ser_rvalid_o, mb_rvalid_o, diff_clr_o, loop_open_o;
	wire logic		idx_out_o, slowdown_o, move_active_o;
	wire logic signed [24:0]	rate_o;
	wire logic [1:0]	stat_o;
	int			fail_count = 0;
	int			samples_checked = 0;
	int			n_clr = 0;
	int			n_idx = 0;
	logic [16:0]		q;
	logic signed [24:0]	r;
	logic [15:0]		mba [5] = '{16'hff04, 16'hff06, 16'hff12,
					16'hff16, 16'hff00};
	logic [15:0]		sca [4] = '{16'h003c, 16'h0037, 16'h0039,
					16'h0045};

	dcu_top u_dut (.*);
	dcu_host u_host (.clk_sys_i, .ser_wr_o(ser_wr_i), .ser_rd_o(ser_rd_i),
		.ser_code_o(ser_code_i), .ser_wdata_o(ser_wdata_i),
		.ser_rdata_i(ser_rdata_o), .ser_rvalid_i(ser_rvalid_o),
		.mb_wr_o(mb_wr_i), .mb_rd_o(mb_rd_i), .mb_addr_o(mb_addr_i),
		.mb_wdata_o(mb_wdata_i), .mb_rdata_i(mb_rdata_o),
		.mb_rvalid_i(mb_rvalid_o));

	always #12.5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		n_clr += int'(diff_clr_o === 1'h1);
		n_idx += int'(idx_out_o === 1'h1);
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#2;
	endtask
	task automatic chk(input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic do_reset;
		srst_i = 1'h1;
		cyc(3);
		srst_i = 1'h0;
	endtask
	task automatic steps(input int n);
		repeat (n) begin
			out_step_i = 1'h1;
			cyc(1);
			out_step_i = 1'h0;
			cyc(1);
		end
		cyc(3);
	endtask
	task automatic end_of_test;
		$display("Checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		cyc(60000);
		fail_count++;
		$display("Error at %0t: run limit reached", $time);
		end_of_test;
	end

	initial begin
		ctl_in_i = 4'h0;
		in_pol_i = 4'hf;
		in_func_i = 16'hc921;
		alt_mode_i = 2'h0;
		manual_rate_i = 24'h00_03e8;
		ramp_time_i = 16'h0000;
		dir_cmd_i = 1'h0;
		out_sel_i = 8'h63;
		ofs_inc_i = 1'h0;
		ofs_dec_i = 1'h0;
		idx_in_i = 1'h0;
		out_step_i = 1'h0;
		idx_period_i = 16'h0004;
		do_reset;
		chk({loop_open_o, slowdown_o, move_active_o, stat_o}, 0);
		foreach (mba[i]) begin
			u_host.rd(1'h1, mba[i], q);
			chk(q, 17'h1_0000);
		end
		for (int i = 0; i < 4; i++) begin
			u_host.wr(1'h1, mba[i], 16'h0001);
			u_host.rd(1'h0, sca[i], q);
			chk(q, 17'h1_0001);
			u_host.wr(1'h0, sca[i], 16'h0000);
			u_host.rd(1'h1, mba[i], q);
			chk(q, 17'h1_0000);
		end
		chk(n_clr, 1);
		$display("Command ports done");
		ctl_in_i[2] = 1'h1;
		cyc(4);
		chk(slowdown_o, 1);
		in_pol_i[2] = 1'h0;
		cyc(4);
		chk(slowdown_o, 0);
		ctl_in_i[2] = 1'h0;
		cyc(4);
		chk(slowdown_o, 1);
		in_pol_i[2] = 1'h1;
		cyc(3);
		chk(slowdown_o, 0);
		in_func_i[15:12] = 4'h9;
		ctl_in_i[3] = 1'h1;
		cyc(4);
		chk(slowdown_o, 1);
		ctl_in_i[3] = 1'h0;
		in_func_i[15:12] = 4'hc;
		$display("Polarity done");
		ofs_inc_i = 1'h1;
		cyc(3);
		ofs_inc_i = 1'h0;
		ofs_dec_i = 1'h1;
		cyc(4);
		ofs_dec_i = 1'h0;
		u_host.rd(1'h0, 16'(dcu_pkg::SER_TALLY), q);
		chk(q, 17'h1_ffff);
		for (int m = 0; m < 2; m++) begin
			alt_mode_i = 2'(m);
			n_clr = 0;
			ctl_in_i[0] = 1'h1;
			cyc(6);
			ctl_in_i[0] = 1'h0;
			chk(n_clr, 1);
			u_host.rd(1'h0, 16'(dcu_pkg::SER_TALLY), q);
			chk(q, m ? 17'h1_0000 : 17'h1_ffff);
		end
		alt_mode_i = 2'h0;
		$display("Clear and tally done");
		ctl_in_i[1] = 1'h1;
		cyc(4);
		chk({loop_open_o, rate_o}, 26'h200_0001);
		chk(stat_o, 2'h1);
		out_sel_i = 8'h36;
		cyc(2);
		chk(stat_o, 2'h2);
		out_sel_i = 8'h05;
		cyc(2);
		chk(stat_o, 2'h0);
		out_sel_i = 8'h63;
		ctl_in_i[1] = 1'h0;
		cyc(4);
		chk({loop_open_o, rate_o}, 0);
		$display("Decouple done");
		u_host.jog(1'h1);
		cyc(4);
		chk(rate_o, 25'h3e8);
		chk({move_active_o, stat_o}, 3'h7);
		manual_rate_i = 24'h00_05dc;
		cyc(4);
		chk(rate_o, 25'h5dc);
		u_host.jog(1'h0);
		cyc(4);
		chk({move_active_o, stat_o, rate_o}, 28'h200_0001);
		dir_cmd_i = 1'h1;
		u_host.jog(1'h1);
		cyc(4);
		chk(rate_o, -25'h5dc);
		chk(stat_o, 2'h2);
		u_host.jog(1'h0);
		dir_cmd_i = 1'h0;
		cyc(4);
		in_func_i[11:8] = 4'h4;
		ctl_in_i[2] = 1'h1;
		cyc(4);
		chk(rate_o, 25'h5dc);
		ctl_in_i[2] = 1'h0;
		cyc(4);
		chk(move_active_o, 0);
		in_func_i[11:8] = 4'h9;
		$display("Jump moves done");
		do_reset;
		manual_rate_i = 24'h06_1a80;
		ramp_time_i = 16'h0001;
		u_host.jog(1'h1);
		cyc(8);
		r = rate_o;
		cyc(100);
		chk(rate_o - r, 25'h64);
		u_host.jog(1'h0);
		cyc(8);
		r = rate_o;
		cyc(50);
		chk(r - rate_o, 25'h32);
		chk(stat_o[1], 1);
		u_host.jog(1'h1);
		cyc(4);
		chk(rate_o < 25'sh10, 1);
		cyc(200);
		u_host.jog(1'h0);
		cyc(4);
		alt_mode_i = 2'h1;
		u_host.jog(1'h1);
		cyc(4);
		chk(rate_o > 25'sh96, 1);
		alt_mode_i = 2'h0;
		do_reset;
		$display("Ramps done");
		n_idx = 0;
		steps(8);
		chk(n_idx, 2);
		idx_in_i = 1'h1;
		u_host.wr(1'h1, dcu_pkg::MB_ALIGN, dcu_pkg::CMD_SET);
		cyc(4);
		steps(8);
		chk(n_idx, 2);
		idx_in_i = 1'h0;
		steps(3);
		chk(n_idx, 2);
		steps(1);
		chk(n_idx, 3);
		u_host.wr(1'h1, dcu_pkg::MB_ALIGN, dcu_pkg::CMD_RELEASE);
		idx_in_i = 1'h1;
		// Align level drops one edge after the write lands
		cyc(2);
		steps(4);
		chk(n_idx, 4);
		ctl_in_i[3] = 1'h1;
		cyc(2);
		steps(4);
		chk(n_idx, 4);
		ctl_in_i[3] = 1'h0;
		idx_in_i = 1'h0;
		idx_period_i = 16'h0002;
		cyc(2);
		steps(4);
		chk(n_idx, 6);
		$display("Index done");
		end_of_test;
	end
endmodule
`default_nettype wire
